// ===== hdl/wfl_core.sv
// Summary of operation
// - Four LED outputs; one always shows twisted-pair link status.
// - Each programmable LED ANDs status signals with enables, then ORs them.
// - Status inputs: collision, duplex, jabber, link, rx, polarity, match, tx.
// - Each programmable LED may bypass its pulse stretcher.
// - Stretcher is a three-stage zero-fill shift register on a 38 Hz tick.
// - Active OR term sets all three stages at once.
// - Wake mode entry waits for transfers in progress, then suspends traffic.
// - Wake frame holds station address sixteen times in a row, LSB first.
// - Register accesses keep working while suspended in wake mode.
// - In wake mode every received frame is discarded from the FIFO.
// - With prerequisite set, sleep pin low enters wake mode, high leaves.
// - Software enable bit forces wake mode once prerequisite is set; clearing it returns to normal.
// - Prerequisite bit turns the sleep pin into a wake enable input.
// - Wake frame sets received flag; writing one clears it.
// - Interrupt unmask bit gates the received flag toward the interrupt pin.
// - Interrupt needs both unmask bit and global interrupt enable.
// - Any LED lights on wake frame when its wake enable bit is set.
// - LED 2 polarity can be inverted by its config bit.
// - Wake LED indication clears on stop, reset-register read, or any mode write with the software enable bit zero.
// - Wake bits clear on reset or reset-register read; unmask also on stop.
// - Interrupt stays inactive when global interrupt enable is zero.
`timescale 1ns/100ps
`include "wfl_params.svh"
module wfl_core
   import wfl_pkg::*;
#(
   parameter logic [47:0] STATION_ADDR = 48'h0000000000a1
)
(
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   input wire wfl_reg_req_t mode_req_i,
   output logic [15:0] mode_rdata_o,
   input wire wfl_reg_req_t led1_req_i,
   input wire wfl_reg_req_t led2_req_i,
   input wire wfl_reg_req_t led3_req_i,
   output logic [15:0] led1_rdata_o,
   output logic [15:0] led2_rdata_o,
   output logic [15:0] led3_rdata_o,
   input wire logic reset_reg_rd_i,
   input wire logic stop_i,
   input wire logic global_irq_enable_i,
   input wire logic sleep_n_i,
   output logic sleep_o,
   input wire wfl_status_t status_i,
   input wire logic tx_busy_i,
   input wire logic rx_busy_i,
   input wire logic rx_valid_i,
   input wire logic rx_data_i,
   input wire logic rx_frame_i,
   output logic suspend_o,
   output logic rx_discard_o,
   output logic irq_o,
   output logic link_led_o,
   output logic [2:0] led_o
);
   logic wake_prereq;
   logic wake_soft_enable;
   logic wake_irq_unmask;
   logic wake_received_flag;
   logic wake_led;
   logic [15:0] led_cfg [3];
   wfl_reg_req_t led_req [3];
   logic [2:0] led_raw;
   logic tick;
   logic wake_req;
   logic hit;
   wfl_state_t state;
   wfl_state_t next_state;
   logic [47:0] addr_shift;
   logic [5:0] bit_cnt;
   logic [4:0] rep_cnt;
   logic [47:0] station_phys_addr;
   logic soft_clr;

   assign led_req[0] = led1_req_i;
   assign led_req[1] = led2_req_i;
   assign led_req[2] = led3_req_i;
   assign soft_clr = reset_reg_rd_i;

   // Prerequisite bit claims the sleep pin as a wake input
   assign wake_req = wake_soft_enable
      | (wake_prereq & ~sleep_n_i);
   assign sleep_o = ~wake_prereq & ~sleep_n_i;

   // Mode control bits; register path is never gated by suspend
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wake_prereq <= 1'b0;
         wake_soft_enable <= 1'b0;
      end else if (soft_clr) begin
         wake_prereq <= 1'b0;
         wake_soft_enable <= 1'b0;
      end else if (mode_req_i.wr) begin
         wake_prereq <= mode_req_i.wdata[`WFL_PREREQ_BIT];
         // Soft enable is ignored until prerequisite is set
         wake_soft_enable <= mode_req_i.wdata[`WFL_SOFT_EN_BIT] & wake_prereq;
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wake_irq_unmask <= 1'b0;
      end else if (soft_clr || stop_i) begin
         wake_irq_unmask <= 1'b0;
      end else if (mode_req_i.wr) begin
         wake_irq_unmask <= mode_req_i.wdata[`WFL_IRQ_UNMASK_BIT];
      end
   end

   // Hit wins over a write-one clear in the same cycle
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wake_received_flag <= 1'b0;
      end else if (soft_clr) begin
         wake_received_flag <= 1'b0;
      end else if (hit) begin
         wake_received_flag <= 1'b1;
      end else if (mode_req_i.wr && mode_req_i.wdata[`WFL_RCVD_FLAG_BIT]) begin
         wake_received_flag <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wake_led <= 1'b0;
      end else if (stop_i || soft_clr) begin
         wake_led <= 1'b0;
      end else if (hit) begin
         wake_led <= 1'b1;
      end else if (mode_req_i.wr && !mode_req_i.wdata[`WFL_SOFT_EN_BIT]) begin
         // Clearing is a write event, so a pin-started wake mode still lights
         wake_led <= 1'b0;
      end
   end

   always_comb begin
      mode_rdata_o = 16'h0000;
      mode_rdata_o[`WFL_PREREQ_BIT] = wake_prereq;
      mode_rdata_o[`WFL_SOFT_EN_BIT] = wake_soft_enable;
      mode_rdata_o[`WFL_IRQ_UNMASK_BIT] = wake_irq_unmask;
      mode_rdata_o[`WFL_RCVD_FLAG_BIT] = wake_received_flag;
   end

   // Both enables are required; global enable alone blocks the pin
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= wake_received_flag & wake_irq_unmask
            & global_irq_enable_i;
      end
   end

   // Drain lets frames in flight finish before traffic stops
   always_comb begin
      next_state = state;
      case (state)
         WFL_NORMAL: begin
            if (wake_req) begin
               next_state = WFL_DRAIN;
            end
         end
         WFL_DRAIN: begin
            if (!wake_req) begin
               next_state = WFL_NORMAL;
            end else if (!tx_busy_i && !rx_busy_i) begin
               next_state = WFL_SUSPEND;
            end
         end
         WFL_SUSPEND: begin
            if (!wake_req) begin
               next_state = WFL_NORMAL;
            end
         end
         default: next_state = WFL_NORMAL;
      endcase
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state <= WFL_NORMAL;
      end else begin
         state <= next_state;
      end
   end

   assign suspend_o = (state == WFL_SUSPEND);
   assign rx_discard_o = suspend_o & rx_frame_i;

   // No register path reaches the station address here, so a parameter holds it
   assign station_phys_addr = STATION_ADDR;

   // Bitwise matcher: sliding 48-bit window, count consecutive aligned copies
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         addr_shift <= 48'h000000000000;
         bit_cnt <= 6'h00;
         rep_cnt <= 5'h00;
      end else if (!suspend_o || !rx_frame_i) begin
         addr_shift <= 48'h000000000000;
         bit_cnt <= 6'h00;
         rep_cnt <= 5'h00;
      end else if (rx_valid_i) begin
         // LSB arrives first, so shift in from the top
         addr_shift <= {rx_data_i, addr_shift[47:1]};
         if (rep_cnt != 5'h00 && bit_cnt != 6'd47) begin
            bit_cnt <= bit_cnt + 6'h01;
         end else if ({rx_data_i, addr_shift[47:1]} == station_phys_addr) begin
            bit_cnt <= 6'h00;
            if (rep_cnt != 5'h10) begin
               rep_cnt <= rep_cnt + 5'h01;
            end
         end else if (rep_cnt != 5'h00) begin
            // Broken run: restart search from this bit
            bit_cnt <= 6'h00;
            rep_cnt <= 5'h00;
         end
      end
   end

   assign hit = suspend_o & rx_valid_i & (rep_cnt == 5'h0f) & (bit_cnt == 6'd47)
      & ({rx_data_i, addr_shift[47:1]} == station_phys_addr);

   wfl_tick_gen u_tick (
      .ref_clk_i(ref_clk_i),
      .rst_n_i(rst_n_i),
      .tick_o(tick)
   );

   genvar g;
   generate
      for (g = 0; g < 3; g++) begin : g_led
         always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
               led_cfg[g] <= `WFL_LED_RST;
            end else if (led_req[g].wr) begin
               led_cfg[g] <= led_req[g].wdata;
            end
         end
         wfl_led_chan u_chan (
            .ref_clk_i(ref_clk_i),
            .rst_n_i(rst_n_i),
            .tick_i(tick),
            .status_i(status_i),
            .cfg_i(led_cfg[g]),
            .wake_led_i(wake_led),
            .led_o(led_raw[g])
         );
      end
   endgenerate

   assign led1_rdata_o = led_cfg[0];
   assign led2_rdata_o = led_cfg[1];
   assign led3_rdata_o = led_cfg[2];
   assign led_o[0] = led_raw[0];
   assign led_o[1] = led_raw[1] ^ led_cfg[1][`WFL_LED2_INV_BIT];
   assign led_o[2] = led_raw[2];

   // Dedicated link LED, not programmable
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         link_led_o <= 1'b0;
      end else begin
         link_led_o <= status_i.link_good;
      end
   end

   // Interrupt path
   chk_irq_gate: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      !global_irq_enable_i |=> !irq_o)
      else $error("irq without global enable");
   chk_irq_cause: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      irq_o |-> $past(wake_received_flag) && $past(wake_irq_unmask))
      else $error("irq without flag and unmask");
   chk_irq_set: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      wake_received_flag && wake_irq_unmask && global_irq_enable_i |=> irq_o)
      else $error("irq not raised");
   chk_irq_unmask: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      !wake_irq_unmask |=> !irq_o)
      else $error("irq while masked");
   chk_unmask_stop: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      stop_i |=> !wake_irq_unmask)
      else $error("unmask kept on stop");

   // Control register and received flag
   chk_hit_sets_flag: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      hit && !soft_clr |=> wake_received_flag)
      else $error("hit lost");
   chk_w0_keeps_flag: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      wake_received_flag && !soft_clr
      && !(mode_req_i.wr && mode_req_i.wdata[`WFL_RCVD_FLAG_BIT]) |=> wake_received_flag)
      else $error("flag dropped");
   chk_w1_clears: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      wake_received_flag && !hit && mode_req_i.wr && mode_req_i.wdata[`WFL_RCVD_FLAG_BIT]
      |=> !wake_received_flag)
      else $error("flag kept after write one");
   chk_flag_cause: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      $rose(wake_received_flag) |-> $past(hit))
      else $error("flag set without wake frame");
   chk_soft_refused: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      mode_req_i.wr && !wake_prereq |=> !wake_soft_enable)
      else $error("soft enable taken without prerequisite");
   chk_write_in_wake: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      suspend_o && mode_req_i.wr && !soft_clr
      |=> wake_prereq == $past(mode_req_i.wdata[`WFL_PREREQ_BIT]))
      else $error("write lost in wake mode");
   chk_reset_read: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      soft_clr |=> mode_rdata_o == 16'h0000)
      else $error("wake bits kept after reset read");

   // Mode sequencing
   chk_pin_entry: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      state == WFL_NORMAL && wake_prereq && !sleep_n_i |=> state == WFL_DRAIN)
      else $error("sleep pin ignored");
   chk_pin_exit: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      suspend_o && !wake_soft_enable && sleep_n_i |=> !suspend_o)
      else $error("sleep pin release ignored");
   chk_soft_entry: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      state == WFL_NORMAL && wake_soft_enable |=> state == WFL_DRAIN)
      else $error("soft enable ignored");
   chk_leave_wake: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      suspend_o && !wake_req |=> !suspend_o)
      else $error("wake mode not left");
   chk_drain_wait: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      state == WFL_DRAIN && (tx_busy_i || rx_busy_i) |=> state != WFL_SUSPEND)
      else $error("suspended during traffic");
   chk_drain_done: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      state == WFL_DRAIN && wake_req && !tx_busy_i && !rx_busy_i |=> suspend_o)
      else $error("drain did not finish");
   chk_discard: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      suspend_o && rx_frame_i |-> rx_discard_o)
      else $error("frame not discarded");
   chk_single_hit: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      hit |=> !hit)
      else $error("wake frame counted twice");

   // Indicators
   chk_led_wake_clr: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      stop_i |=> !wake_led)
      else $error("wake led held after stop");
   chk_wake_led_set: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      hit && !stop_i && !soft_clr |=> wake_led)
      else $error("wake led not set");
   chk_link_led: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      status_i.link_good |=> link_led_o)
      else $error("link led wrong");
   chk_link_led_off: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      !status_i.link_good |=> !link_led_o)
      else $error("link led lit on link down");
endmodule

// ===== hdl/wfl_led_chan.sv
`timescale 1ns/100ps
`include "wfl_params.svh"
module wfl_led_chan
   import wfl_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   input wire logic tick_i,
   input wire wfl_status_t status_i,
   input wire logic [15:0] cfg_i,
   input wire logic wake_led_i,
   output logic led_o
);
   logic or_term;
   logic [2:0] stretch;

   // Gate every status signal with its enable, then OR
   assign or_term = |(status_i & cfg_i[7:0]);

   // Active term reloads all stages at once; tick shifts zeros in
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         stretch <= 3'h0;
      end else if (or_term) begin
         stretch <= `WFL_STRETCH_ONES;
      end else if (tick_i) begin
         stretch <= {stretch[1:0], 1'b0};
      end
   end

   // Stretcher output or direct OR, plus wake indication
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         led_o <= 1'b0;
      end else begin
         led_o <= (cfg_i[`WFL_LED_STRETCH_BIT] ? stretch[2] : or_term)
            | (wake_led_i & cfg_i[`WFL_LED_WAKE_BIT]);
      end
   end

   chk_stretch_load: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      or_term |=> stretch == `WFL_STRETCH_ONES)
      else $error("stretcher not loaded");
endmodule

// ===== hdl/wfl_params.svh
`ifndef WFL_PARAMS_SVH
`define WFL_PARAMS_SVH
// Bit positions in the wake mode control register
`define WFL_PREREQ_BIT 1
`define WFL_SOFT_EN_BIT 2
`define WFL_IRQ_UNMASK_BIT 3
`define WFL_RCVD_FLAG_BIT 4
// Bit positions in each LED configuration register
`define WFL_LED_WAKE_BIT 9
`define WFL_LED2_INV_BIT 14
`define WFL_LED_STRETCH_BIT 15
// Global interrupt enable position in the controller status register
`define WFL_GLOBAL_IRQ_EN_BIT 6
// Register reset values
`define WFL_MODE_RST 16'h0000
`define WFL_LED_RST 16'h0000
// Stretcher tick timing
`define WFL_CLK_HZ 100000000
`define WFL_TICK_HZ 38
`define WFL_TICK_CYCLES (`WFL_CLK_HZ / `WFL_TICK_HZ)
`define WFL_STRETCH_ONES 3'h7
`endif

// ===== hdl/wfl_pkg.sv
package wfl_pkg;
   typedef struct packed {
      logic transmitting_active;
      logic rx_match_active;
      logic rx_polarity_ok;
      logic receiving_active;
      logic link_good;
      logic jabber_active;
      logic full_duplex_up;
      logic collision;
   } wfl_status_t;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [15:0] wdata;
   } wfl_reg_req_t;

   typedef enum logic [1:0] {
      WFL_NORMAL,
      WFL_DRAIN,
      WFL_SUSPEND
   } wfl_state_t;
endpackage

// ===== hdl/wfl_tick_gen.sv
`timescale 1ns/100ps
`include "wfl_params.svh"
module wfl_tick_gen (
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   output logic tick_o
);
   localparam int unsigned TICK_N = `WFL_TICK_CYCLES;
   logic [21:0] count;

   // Free-running divider; one-cycle pulse per period
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         count <= 22'h000000;
         tick_o <= 1'b0;
      end else if (count == 22'(TICK_N - 1)) begin
         count <= 22'h000000;
         tick_o <= 1'b1;
      end else begin
         count <= count + 22'h000001;
         tick_o <= 1'b0;
      end
   end
endmodule

// ===== testbench/tb_wake_frame_led_status.sv
`timescale 1ns/100ps
module tb_wake_frame_led_status
   import wfl_pkg::*;
;
   // Same value as the core's default station address
   localparam logic [47:0] ADDR = 48'h0000000000a1;
   logic ref_clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   wfl_reg_req_t mode_req = '0;
   wfl_reg_req_t led_req [0:3] = '{default: '0};
   logic [15:0] mode_rd;
   logic [15:0] led_rd [1:3];
   logic reset_rd = 1'b0, stop = 1'b0, gie = 1'b0, sleep_n = 1'b1;
   logic tx_busy = 1'b0, rx_busy = 1'b0, src_start = 1'b0;
   logic [4:0] src_reps = 5'h00;
   wfl_status_t status = '0;
   logic sleep, suspend, discard, irq, link_led, src_busy, rx_valid, rx_data, rx_frame;
   logic [2:0] led;
   int fail_count = 0;
   int check_count = 0;

   always #5 ref_clk_i = ~ref_clk_i;

   wfl_core #(.STATION_ADDR(ADDR)) dut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
      .mode_req_i(mode_req), .mode_rdata_o(mode_rd), .led1_req_i(led_req[1]),
      .led2_req_i(led_req[2]),
      .led3_req_i(led_req[3]), .led1_rdata_o(led_rd[1]), .led2_rdata_o(led_rd[2]),
      .led3_rdata_o(led_rd[3]), .reset_reg_rd_i(reset_rd), .stop_i(stop),
      .global_irq_enable_i(gie), .sleep_n_i(sleep_n), .sleep_o(sleep), .status_i(status),
      .tx_busy_i(tx_busy), .rx_busy_i(rx_busy), .rx_valid_i(rx_valid), .rx_data_i(rx_data),
      .rx_frame_i(rx_frame), .suspend_o(suspend), .rx_discard_o(discard), .irq_o(irq),
      .link_led_o(link_led), .led_o(led));

   wfl_net_src #(.STATION_ADDR(ADDR)) src (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
      .start_i(src_start), .reps_i(src_reps), .busy_o(src_busy), .rx_valid_o(rx_valid),
      .rx_data_o(rx_data), .rx_frame_o(rx_frame));

   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk_i);
      @(negedge ref_clk_i);
   endtask

   task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
      check_count++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // Register 0 is wake mode control, 1..3 the LED configurations
   task automatic wr(input int sel, input logic [15:0] d);
      @(posedge ref_clk_i);
      if (sel == 0) begin
         mode_req.wr <= 1'b1;
         mode_req.wdata <= d;
      end else begin
         led_req[sel].wr <= 1'b1;
         led_req[sel].wdata <= d;
      end
      @(posedge ref_clk_i);
      mode_req.wr <= 1'b0;
      led_req[sel].wr <= 1'b0;
      @(negedge ref_clk_i);
   endtask

   task automatic send(input logic [4:0] n);
      int i;
      @(posedge ref_clk_i);
      src_start <= 1'b1;
      src_reps <= n;
      @(posedge ref_clk_i);
      src_start <= 1'b0;
      cyc(5);
      chk("discard", 16'h1, 16'(discard));
      for (i = 0; i < 1000 && src_busy; i++) @(posedge ref_clk_i);
      if (src_busy) begin
         fail_count++;
         print_verdict();
      end
      cyc(3);
   endtask

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   initial begin
      repeat (10) @(posedge ref_clk_i);
      rst_n_i <= 1'b1;
      cyc(1);
      chk("mode reset", 16'h0000, mode_rd);
      for (int k = 1; k < 4; k++) chk("led cfg reset", 16'h0000, led_rd[k]);
      chk("led reset", 16'h0, 16'(led));
      @(posedge ref_clk_i);
      status.link_good <= 1'b1;
      cyc(2);
      chk("link led", 16'h1, 16'(link_led));
      for (int k = 0; k < 8; k++) begin
         wr(1, 16'h0001 << k);
         @(posedge ref_clk_i);
         status <= wfl_status_t'(8'h01 << k);
         cyc(2);
         chk("led1 enabled", 16'h1, 16'(led[0]));
         @(posedge ref_clk_i);
         status <= wfl_status_t'(~(8'h01 << k));
         cyc(2);
         chk("led1 masked", 16'h0, 16'(led[0]));
      end
      // Reset mid-run empties the stretcher stages that the loop above filled
      @(posedge ref_clk_i);
      status <= '0;
      rst_n_i <= 1'b0;
      cyc(3);
      @(posedge ref_clk_i);
      rst_n_i <= 1'b1;
      // A single-cycle pulse must still light a stretched LED
      wr(1, 16'h8001);
      chk("stretch idle", 16'h0, 16'(led[0]));
      @(posedge ref_clk_i);
      status <= wfl_status_t'(8'h01);
      @(posedge ref_clk_i);
      status <= '0;
      cyc(1);
      chk("stretch set", 16'h1, 16'(led[0]));
      cyc(20);
      chk("stretch hold", 16'h1, 16'(led[0]));
      wr(1, 16'h0000);
      wr(2, 16'h4000);
      cyc(2);
      chk("led2 invert", 16'h1, 16'(led[1]));
      wr(2, 16'h0000);
      wr(0, 16'h0004);
      chk("soft refused", 16'h0000, mode_rd);
      @(posedge ref_clk_i);
      sleep_n <= 1'b0;
      cyc(3);
      chk("plain sleep", 16'h1, 16'(sleep));
      chk("no suspend", 16'h0, 16'(suspend));
      wr(0, 16'h0002);
      cyc(3);
      chk("sleep redefined", 16'h0, 16'(sleep));
      chk("pin suspend", 16'h1, 16'(suspend));
      @(posedge ref_clk_i);
      sleep_n <= 1'b1;
      tx_busy <= 1'b1;
      rx_busy <= 1'b1;
      cyc(3);
      chk("pin release", 16'h0, 16'(suspend));
      wr(0, 16'h0006);
      cyc(5);
      chk("drain wait", 16'h0, 16'(suspend));
      @(posedge ref_clk_i);
      tx_busy <= 1'b0;
      cyc(3);
      chk("drain rx wait", 16'h0, 16'(suspend));
      @(posedge ref_clk_i);
      rx_busy <= 1'b0;
      cyc(3);
      chk("soft suspend", 16'h1, 16'(suspend));
      wr(0, 16'h000e);
      chk("access in suspend", 16'h000e, mode_rd);
      wr(3, 16'h0200);
      send(5'd15);
      chk("short frame", 16'h000e, mode_rd);
      send(5'd16);
      chk("wake flag", 16'h001e, mode_rd);
      chk("irq gated", 16'h0, 16'(irq));
      chk("wake led", 16'h1, 16'(led[2]));
      @(posedge ref_clk_i);
      gie <= 1'b1;
      cyc(2);
      chk("irq on", 16'h1, 16'(irq));
      wr(0, 16'h0006);
      cyc(2);
      chk("irq masked", 16'h0, 16'(irq));
      chk("write zero keeps", 16'h0016, mode_rd);
      wr(0, 16'h0016);
      chk("write one clears", 16'h0006, mode_rd);
      @(posedge ref_clk_i);
      stop <= 1'b1;
      @(posedge ref_clk_i);
      stop <= 1'b0;
      cyc(2);
      chk("wake led stop", 16'h0, 16'(led[2]));
      send(5'd16);
      chk("wake led again", 16'h1, 16'(led[2]));
      wr(0, 16'h0012);
      cyc(2);
      chk("wake led off", 16'h0, 16'(led[2]));
      chk("normal again", 16'h0, 16'(suspend));
      wr(0, 16'h000a);
      @(posedge ref_clk_i);
      stop <= 1'b1;
      cyc(2);
      chk("stop unmask", 16'h0002, mode_rd);
      @(posedge ref_clk_i);
      stop <= 1'b0;
      reset_rd <= 1'b1;
      @(posedge ref_clk_i);
      reset_rd <= 1'b0;
      cyc(1);
      chk("reset read", 16'h0000, mode_rd);
      print_verdict();
   end
endmodule

// ===== testbench/wfl_net_src.sv
`timescale 1ns/100ps
module wfl_net_src #(
   parameter logic [47:0] STATION_ADDR = 48'h0000000000a1
) (
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   input wire logic start_i,
   input wire logic [4:0] reps_i,
   output logic busy_o,
   output logic rx_valid_o,
   output logic rx_data_o,
   output logic rx_frame_o
);
   logic [9:0] bit_cnt;
   logic [9:0] bit_total;

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         busy_o <= 1'b0;
         rx_valid_o <= 1'b0;
         rx_data_o <= 1'b0;
         rx_frame_o <= 1'b0;
         bit_cnt <= 10'h000;
         bit_total <= 10'h000;
      end else if (start_i && !busy_o) begin
         busy_o <= 1'b1;
         rx_frame_o <= 1'b1;
         bit_cnt <= 10'h000;
         bit_total <= 10'(reps_i) * 10'h030;
      end else if (busy_o) begin
         if (bit_cnt == bit_total) begin
            busy_o <= 1'b0;
            rx_frame_o <= 1'b0;
            rx_valid_o <= 1'b0;
         end else begin
            rx_valid_o <= 1'b1;
            rx_data_o <= STATION_ADDR[6'(bit_cnt % 10'h030)];
            bit_cnt <= bit_cnt + 10'h001;
         end
      end else begin
         rx_valid_o <= 1'b0;
         // Idle line toggles so a stale bit never looks valid
         rx_data_o <= ~rx_data_o;
      end
   end
endmodule
